// ---- hdl/bpcd_port.sv ----
// Group C and D general-purpose pin logic with peripheral overrides, APB register access
//
// What this block does
// - Group-D direction one makes the pin an input, driver released.
// - Group-D direction zero drives the pin from the output latch.
// - Group-D latch has its own address; reads return latch, not pins.
// - Reset makes every group-D pin a digital input.
// - Bit 7 of group-E pin register enables all group-D pull-ups.
// - A group-D pull-up is off whenever that pin is an output.
// - Reset clears the group-D pull-up enable.
// - Timer-1 oscillator takes group-C pins 0 and 1, digital paths off.
// - Group-C pins 4 and 5 are input only, no latch or direction bits.
// - Serial transmit overrides latch on group-C pin 6; software sets output.
// - Two-wire mode clock and data override latch on group-D pins 0, 1.
// - Parallel master port data rides group-D pins, direction from direction bits.
// - Group-D registers exist only in the larger package variant.
// - Group-C pin 1 can drive the external transceiver output enable.
// - Reset makes group-C pin 2 analog, others except 4 and 5 digital inputs.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bpcd_port
    import bpcd_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Group C pins
    input  wire logic [7:0]  group_c_pin_in,
    output logic      [7:0]  group_c_pin_out,
    output logic      [7:0]  group_c_pin_oe_n,
    output logic             timer1_osc_active,
    output logic             analog_channel_eleven_sel,
    // Group D pins
    input  wire logic [7:0]  group_d_pin_in,
    output logic      [7:0]  group_d_pin_out,
    output logic      [7:0]  group_d_pin_oe_n,
    output logic      [7:0]  group_d_pullup_on,
    // Group E pin levels (read only here)
    input  wire logic [2:0]  group_e_pin_in,
    // Peripheral sources
    input  wire logic        async_serial_tx,
    input  wire logic        sync_serial_clock,
    input  wire logic        sync_serial_data,
    input  wire logic        sync_serial_data_drive,
    input  wire logic        second_two_wire_clock,
    input  wire logic        second_two_wire_data,
    input  wire logic [7:0]  parallel_master_data_bit,
    input  wire logic        ext_transceiver_output_enable_n,
    // Peripheral sinks
    output logic      [7:0]  parallel_master_data_in,
    output logic             sync_serial_data_in,
    output logic             second_two_wire_clock_in,
    output logic             second_two_wire_data_in
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0]  c_sync1;
        logic [7:0]  c_sync2;
        logic [7:0]  d_sync1;
        logic [7:0]  d_sync2;
        logic [2:0]  e_sync1;
        logic [2:0]  e_sync2;
        logic [7:0]  c_lat;
        logic [7:0]  c_dir;
        logic [7:0]  d_lat;
        logic [7:0]  d_dir;
        logic [1:0]  e_pu;
        logic [6:0]  periph;
        logic        rvalid;
        logic [31:0] rdata;
    } bpcd_state_t;

    bpcd_state_t s_q;
    bpcd_state_t s_d;

    logic        acc;
    logic        wr;
    logic        mapped;
    logic [7:0]  wbyte;
    logic [7:0]  d_dir_eff;
    logic [7:0]  d_out;
    logic        osc_on;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // Writes finish in the first access cycle; reads take one wait state so
    // that registered read data already stands when pready is high
    assign acc     = psel & penable;
    assign wr      = acc & pwrite & pstrb[0];
    assign wbyte   = pwdata[7:0];
    assign pready  = ~(acc & ~pwrite) | s_q.rvalid;
    assign pslverr = acc & ~mapped;
    assign prdata  = s_q.rdata;

    // Group-D addresses only decode in the larger variant
    always_comb begin
        unique case (paddr)
            BPCD_OFF_C_PIN, BPCD_OFF_C_LAT, BPCD_OFF_C_DIR,
            BPCD_OFF_E_PIN, BPCD_OFF_PERIPH: mapped = 1'b1;
            BPCD_OFF_D_PIN, BPCD_OFF_D_LAT, BPCD_OFF_D_DIR: mapped = LARGE_PKG;
            default: mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        // Two-flop synchronisers on pin levels
        s_d.c_sync1 = group_c_pin_in;
        s_d.c_sync2 = s_q.c_sync1;
        s_d.d_sync1 = group_d_pin_in;
        s_d.d_sync2 = s_q.d_sync1;
        s_d.e_sync1 = group_e_pin_in;
        s_d.e_sync2 = s_q.e_sync1;
        // Register writes
        if (wr) begin
            unique case (paddr)
                BPCD_OFF_C_PIN,
                BPCD_OFF_C_LAT: s_d.c_lat = wbyte & BPCD_C_IMPL;
                BPCD_OFF_C_DIR: s_d.c_dir = (wbyte & BPCD_C_IMPL) | ~BPCD_C_IMPL;
                BPCD_OFF_D_PIN,
                BPCD_OFF_D_LAT: if (LARGE_PKG) s_d.d_lat = wbyte;
                BPCD_OFF_D_DIR: if (LARGE_PKG) s_d.d_dir = wbyte;
                BPCD_OFF_E_PIN: s_d.e_pu = {wbyte[BPCD_E_DPU_BIT], wbyte[BPCD_E_EPU_BIT]};
                BPCD_OFF_PERIPH: s_d.periph = wbyte[6:0];
                default: ;
            endcase
        end
        // Read data captured in the first access cycle, shown in the second
        s_d.rvalid = acc && !pwrite && !s_q.rvalid;
        if (acc && !pwrite && !s_q.rvalid) begin
            unique case (paddr)
                BPCD_OFF_C_PIN: s_d.rdata = {24'h0, s_q.c_sync2 & BPCD_C_PIN_IMPL
                                             & ~{6'h00, {2{osc_on}}}};
                BPCD_OFF_C_LAT: s_d.rdata = {24'h0, s_q.c_lat};
                BPCD_OFF_C_DIR: s_d.rdata = {24'h0, s_q.c_dir & BPCD_C_IMPL};
                BPCD_OFF_D_PIN: s_d.rdata = LARGE_PKG ? {24'h0, s_q.d_sync2} : 32'h0;
                BPCD_OFF_D_LAT: s_d.rdata = LARGE_PKG ? {24'h0, s_q.d_lat} : 32'h0;
                BPCD_OFF_D_DIR: s_d.rdata = LARGE_PKG ? {24'h0, s_q.d_dir} : 32'h0;
                BPCD_OFF_E_PIN: s_d.rdata = {24'h0, s_q.e_pu, 3'h0, s_q.e_sync2};
                BPCD_OFF_PERIPH: s_d.rdata = {25'h0, s_q.periph};
                default: s_d.rdata = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.c_lat  <= BPCD_LAT_RST;
            s_q.c_dir  <= BPCD_DIR_RST;
            s_q.d_lat  <= BPCD_LAT_RST;
            s_q.d_dir  <= BPCD_DIR_RST;
            s_q.e_pu   <= BPCD_E_PU_RST;
            s_q.periph <= BPCD_PERIPH_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Group C pin drive

    assign osc_on                    = s_q.periph[BPCD_P_T1OSC];
    assign timer1_osc_active         = osc_on;
    // Pin 2 stays analog until software selects digital
    assign analog_channel_eleven_sel = ~s_q.periph[BPCD_P_RC2DIG];

    always_comb begin
        group_c_pin_out  = s_q.c_lat & BPCD_C_IMPL;
        group_c_pin_oe_n = s_q.c_dir | ~BPCD_C_IMPL;
        // Pin 1 carries the external transceiver enable
        if (s_q.periph[BPCD_P_XCVROE]) begin
            group_c_pin_out[1]  = ext_transceiver_output_enable_n;
            group_c_pin_oe_n[1] = 1'b0;
        end
        // Serial transmit or sync clock wins over latch data on pin 6
        if (s_q.periph[BPCD_P_SYNCEN]) begin
            group_c_pin_out[6] = sync_serial_clock;
        end else if (s_q.periph[BPCD_P_TXEN]) begin
            group_c_pin_out[6] = async_serial_tx;
        end
        // Sync data out on pin 7 while the serial unit drives it
        if (s_q.periph[BPCD_P_SYNCEN] && sync_serial_data_drive) begin
            group_c_pin_out[7] = sync_serial_data;
        end
        // Oscillator owns pins 0 and 1: digital drivers off
        if (osc_on) begin
            group_c_pin_out[1:0]  = 2'h0;
            group_c_pin_oe_n[1:0] = 2'h3;
        end
        // Pin 2 in analog mode has no digital driver
        if (!s_q.periph[BPCD_P_RC2DIG]) begin
            group_c_pin_oe_n[2] = 1'b1;
        end
    end

    // Sync data input relies on software making pin 7 an input
    assign sync_serial_data_in = s_q.c_sync2[7];

    ////////////////////////////////////////////////////////////////////////////////
    // Group D pin drive

    assign d_dir_eff = LARGE_PKG ? s_q.d_dir : 8'hff;

    always_comb begin
        d_out = s_q.d_lat;
        if (s_q.periph[BPCD_P_PMPEN]) begin
            d_out = parallel_master_data_bit;
        end
        if (s_q.periph[BPCD_P_TWOWIRE]) begin
            d_out[0] = second_two_wire_clock;
            d_out[1] = second_two_wire_data;
        end
    end

    assign group_d_pin_out   = d_out;
    assign group_d_pin_oe_n  = d_dir_eff;
    // Pull-ups follow the common enable, only on input pins
    assign group_d_pullup_on = {8{s_q.e_pu[1] & LARGE_PKG}} & d_dir_eff;

    // Peripheral sampling of the synchronised pin levels
    assign parallel_master_data_in  = s_q.d_sync2;
    assign second_two_wire_clock_in = s_q.d_sync2[0];
    assign second_two_wire_data_in  = s_q.d_sync2[1];

endmodule : bpcd_port
`default_nettype wire

// ---- shared/bpcd_pkg.sv ----
// Package: register map, field positions and reset values for the group C/D pin block
package bpcd_pkg;
    // Register byte offsets on the APB
    localparam logic [11:0] BPCD_OFF_C_PIN  = 12'h000;
    localparam logic [11:0] BPCD_OFF_C_LAT  = 12'h004;
    localparam logic [11:0] BPCD_OFF_C_DIR  = 12'h008;
    localparam logic [11:0] BPCD_OFF_D_PIN  = 12'h00c;
    localparam logic [11:0] BPCD_OFF_D_LAT  = 12'h010;
    localparam logic [11:0] BPCD_OFF_D_DIR  = 12'h014;
    localparam logic [11:0] BPCD_OFF_E_PIN  = 12'h018;
    localparam logic [11:0] BPCD_OFF_PERIPH = 12'h01c;
    // Implemented bits of group C latch/direction (pins 0,1,2,6,7)
    localparam logic [7:0]  BPCD_C_IMPL     = 8'hc7;
    // Group C pins readable (pin 3 absent)
    localparam logic [7:0]  BPCD_C_PIN_IMPL = 8'hf7;
    // Group E pin register field positions
    localparam int          BPCD_E_DPU_BIT  = 7;
    localparam int          BPCD_E_EPU_BIT  = 6;
    // Peripheral control register field positions
    localparam int          BPCD_P_T1OSC    = 0;
    localparam int          BPCD_P_TXEN     = 1;
    localparam int          BPCD_P_SYNCEN   = 2;
    localparam int          BPCD_P_TWOWIRE  = 3;
    localparam int          BPCD_P_PMPEN    = 4;
    localparam int          BPCD_P_XCVROE   = 5;
    localparam int          BPCD_P_RC2DIG   = 6;
    localparam logic [6:0]  BPCD_PERIPH_RST = 7'h00;
    // Reset values
    localparam logic [7:0]  BPCD_DIR_RST    = 8'hff;
    localparam logic [7:0]  BPCD_LAT_RST    = 8'h00;
    localparam logic [1:0]  BPCD_E_PU_RST   = 2'h0;
endpackage : bpcd_pkg

// ---- tb/bpcd_board.sv ----
// Board model: resolves pin levels from block drivers, pull-ups and board drivers
`timescale 1ns/1ps
`default_nettype none
module bpcd_board (
    input  wire logic       pclk,
    input  wire logic [7:0] d_out,
    input  wire logic [7:0] d_oe_n,
    input  wire logic [7:0] d_pu,
    input  wire logic [7:0] ext_d,
    input  wire logic [7:0] ext_d_en,
    input  wire logic [7:0] c_out,
    input  wire logic [7:0] c_oe_n,
    input  wire logic [7:0] ext_c,
    input  wire logic [7:0] ext_c_en,
    output logic      [7:0] d_pin,
    output logic      [7:0] c_pin
);
    logic [7:0] flt_q = 8'h5a;
    // Undriven lines without pull-up wander every cycle
    always @(posedge pclk) flt_q <= ~flt_q;
    // Block driver first, then board driver, then pull-up or floating level
    assign d_pin = (~d_oe_n & d_out) | (d_oe_n & ext_d_en & ext_d)
                 | (d_oe_n & ~ext_d_en & (d_pu | flt_q));
    assign c_pin = (~c_oe_n & c_out) | (c_oe_n & ext_c_en & ext_c)
                 | (c_oe_n & ~ext_c_en & flt_q);
endmodule : bpcd_board
`default_nettype wire

// ---- tb/bpcd_port_bench.sv ----
// Testbench: register and pin checks of the group C/D pin block over APB
`timescale 1ns/1ps
`default_nettype none
module bpcd_port_bench
    import bpcd_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [7:0]  c_in, c_out, c_oe_n, d_in, d_out, d_oe_n, d_pu, pmd, pmd_in;
    logic [7:0]  ext_c, ext_c_en, ext_d, ext_d_en;
    logic [2:0]  e_in;
    logic        osc, an_sel, tx, s_clk, s_dat, s_drv, tw_clk, tw_dat, xoe_n;
    int          miscompares, total_checks;
    // Block under test and board
    bpcd_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .group_c_pin_in(c_in), .group_c_pin_out(c_out),
        .group_c_pin_oe_n(c_oe_n), .timer1_osc_active(osc), .analog_channel_eleven_sel(an_sel),
        .group_d_pin_in(d_in), .group_d_pin_out(d_out), .group_d_pin_oe_n(d_oe_n),
        .group_d_pullup_on(d_pu), .group_e_pin_in(e_in), .async_serial_tx(tx),
        .sync_serial_clock(s_clk), .sync_serial_data(s_dat), .sync_serial_data_drive(s_drv),
        .second_two_wire_clock(tw_clk), .second_two_wire_data(tw_dat),
        .parallel_master_data_bit(pmd), .ext_transceiver_output_enable_n(xoe_n),
        .parallel_master_data_in(pmd_in), .sync_serial_data_in(), .second_two_wire_clock_in(),
        .second_two_wire_data_in());
    bpcd_board board (.pclk, .d_out, .d_oe_n, .d_pu, .ext_d, .ext_d_en, .c_out, .c_oe_n,
        .ext_c, .ext_c_en, .d_pin(d_in), .c_pin(c_in));
    ////////////////////////////////////////////////////////////////////////////////
    // One APB transfer; response is taken at the falling edge where pready is high, then one idle edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 50)
            miscompares++;
        rdat = prdata;
        serr = pslverr;
        @(posedge pclk);
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : xfer
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(rdat, {24'h0, e});
    endtask : rd
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        miscompares++;
        end_sim();
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, presetn, tx, s_clk, s_dat, s_drv, tw_clk, tw_dat} = '0;
        {paddr, pwdata, pstrb, e_in, pmd, xoe_n} = {12'h0, 32'h0, 4'hf, 3'h5, 8'h96, 1'b1};
        {ext_c, ext_c_en, ext_d, ext_d_en} = {8'hb3, 8'hff, 8'h0c, 8'hff};
        {miscompares, total_checks} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(BPCD_OFF_D_DIR, 8'hff);
        rd(BPCD_OFF_C_DIR, BPCD_C_IMPL);
        rd(BPCD_OFF_E_PIN, 8'h05);
        rd(BPCD_OFF_D_LAT, 8'h00);
        chk(an_sel, 1'b1);
        $display("test reset done");
        wr(BPCD_OFF_D_DIR, 8'h0f);
        wr(BPCD_OFF_D_LAT, 8'ha5);
        rd(BPCD_OFF_D_PIN, 8'hac);
        rd(BPCD_OFF_D_LAT, 8'ha5);
        chk(d_out & ~d_oe_n, 8'ha0);
        wr(BPCD_OFF_E_PIN, 8'h80);
        ext_d_en <= 8'h00;
        chk(d_pu, 8'h0f);
        rd(BPCD_OFF_D_PIN, 8'haf);
        wr(BPCD_OFF_D_PIN, 8'h3c);
        rd(BPCD_OFF_D_LAT, 8'h3c);
        wr(BPCD_OFF_D_DIR, 8'h00);
        tw_clk <= 1'b1;
        wr(BPCD_OFF_PERIPH, 8'h08);
        chk(d_out[1:0], 2'b01);
        wr(BPCD_OFF_PERIPH, 8'h10);
        chk(d_out, 8'h96);
        ext_d_en <= 8'hff;
        wr(BPCD_OFF_D_DIR, 8'hff);
        repeat (3) @(posedge pclk);
        chk(pmd_in, 8'h0c);
        $display("test group d done");
        wr(BPCD_OFF_C_DIR, 8'h3f);
        tx <= 1'b1;
        wr(BPCD_OFF_PERIPH, 8'h42);
        chk({c_out[6], c_oe_n[6], an_sel}, 3'b100);
        rd(BPCD_OFF_C_DIR, 8'h07);
        wr(BPCD_OFF_PERIPH, 8'h43);
        chk({osc, c_oe_n[1:0]}, 3'b111);
        rd(BPCD_OFF_C_PIN, 8'h70);
        xoe_n <= 1'b0;
        wr(BPCD_OFF_PERIPH, 8'h62);
        chk({c_oe_n[1], c_out[1]}, 2'b00);
        rd(12'h020, 8'h00);
        chk(serr, 1'b1);
        $display("test group c done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({d_oe_n, d_pu}, 16'hff00);
        $display("test second reset done");
        end_sim();
    end
endmodule : bpcd_port_bench
`default_nettype wire

// ---- tb/bpcd_port_chk.sv ----
// Checker: direction, pull-up and override relations at the block ports
`timescale 1ns/1ps
`default_nettype none
module bpcd_port_chk
    import bpcd_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [7:0]  group_c_pin_oe_n,
    input wire logic        timer1_osc_active,
    input wire logic        analog_channel_eleven_sel,
    input wire logic [7:0]  group_d_pin_oe_n,
    input wire logic [7:0]  group_d_pullup_on
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_q;
    // Register writes that land at this edge
    assign wr_q = psel && penable && pwrite && pstrb[0];
    ////////////////////////////////////////////////////////////////////////////////
    AST_D_DIR: assert property (wr_q && paddr == BPCD_OFF_D_DIR |=>
        group_d_pin_oe_n == $past(pwdata[7:0])) else $error("D enable not from direction");
    AST_PU_EN: assert property (wr_q && paddr == BPCD_OFF_E_PIN |=>
        group_d_pullup_on == ({8{$past(pwdata[7])}} & group_d_pin_oe_n))
        else $error("D pull-ups not from enable bit");
    AST_PU_OUT: assert property ((group_d_pullup_on & ~group_d_pin_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_PU_RST: assert property ($rose(presetn) |-> group_d_pullup_on == 8'h00)
        else $error("pull-ups on after reset");
    AST_D_RST: assert property ($rose(presetn) |-> group_d_pin_oe_n == 8'hff)
        else $error("D pins not inputs after reset");
    AST_C_RST: assert property ($rose(presetn) |->
        analog_channel_eleven_sel && group_c_pin_oe_n == 8'hff) else $error("C reset state");
    AST_C45: assert property (group_c_pin_oe_n[5:4] == 2'b11)
        else $error("C4 or C5 driven");
    AST_OSC: assert property (timer1_osc_active |-> group_c_pin_oe_n[1:0] == 2'b11)
        else $error("C0 or C1 driven with oscillator on");
    // Main scenarios
    cover property (wr_q && paddr == BPCD_OFF_D_DIR);
    cover property (timer1_osc_active);
    cover property (group_d_pullup_on != 8'h00);
endmodule : bpcd_port_chk
bind bpcd_port bpcd_port_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .group_c_pin_oe_n, .timer1_osc_active, .analog_channel_eleven_sel,
    .group_d_pin_oe_n, .group_d_pullup_on);
`default_nettype wire
